/* File: rtl/fcb_defines.vh */
// Constants for the flash command sequencer: address fields, codes, timings.
// Assumes a 32-bit CPU-side word bus and a 20 MHz core clock.
`ifndef FCB_DEFINES_VH
`define FCB_DEFINES_VH
// Clock period in ns and minimum command-write spacing in clocks
`define FCB_CLK_NS 50
`define FCB_MIN_GAP 15
// Spacing counter load value, minimum gap less one
`define FCB_GAP_LOAD 4'hE
// Command address patterns, address bits [15:8]
`define FCB_ADR_55 8'h55
`define FCB_ADR_AA 8'hAA
// Command data codes
`define FCB_CMD_AA 8'hAA
`define FCB_CMD_55 8'h55
`define FCB_CMD_RD 8'hF0
`define FCB_CMD_ID 8'h90
`define FCB_CMD_PG 8'hA0
`define FCB_CMD_ER 8'h80
`define FCB_CMD_CE 8'h10
`define FCB_CMD_BE 8'h30
`define FCB_CMD_PP 8'h9A
`define FCB_CMD_PE 8'h6A
// Field positions
`define FCB_BLK_HI 18
`define FCB_BLK_LO 17
`define FCB_SEL_HI 15
`define FCB_SEL_LO 14
`define FCB_PAGE_HI 16
`define FCB_PAGE_LO 9
// Array word-address width (4 blocks of 128 kB) and page length in words
`define FCB_ARR_AW 17
`define FCB_PAGE_WORDS 4
// Index of the last word of a page
`define FCB_PAGE_LAST 2'h3
// Automatic operation duration in clocks
`define FCB_PROG_CYC 16'h0040
`define FCB_ERASE_CYC 16'h0100
// Protection reset value
`define FCB_PROT_RST 4'h0
`endif

/* File: rtl/fcb_flash_cmd.v */
// Command sequencer of the on-chip flash: decodes CPU word stores and loads.
// Assumes a CPU that keeps spacing and barriers; sync reset, one clock.
// Functional notes
// R1 - Address bits 1:0 always zero
// R2 - Address bits 7:2 are don't care
// R3 - All cycles writes except three read cycles
// R4 - Command code in data bits 7:0
// R5 - Upper address targets flash, lower holds pattern
// R6 - At least fifteen clocks between command writes
// R7 - Barrier after every command write
// R8 - Identification load then barrier
// R9 - Program words ascend within page
// R10 - Fourth program cycle carries page location
// R11 - Sixth erase cycle carries block selection
// R12 - Protect program selector picks blocks 0 to 3
// R13 - Four contiguous 128 kB erase blocks
// R14 - Command layout accepted from first cycle
// R15 - Busy zero while automatic, failure holds busy
// R16 - Identification mode held until reset command
// R17 - Protected blocks refuse writes
// R18 - Protection erase clears pairs of bits
`timescale 1ns/1ps
`include "fcb_defines.vh"
module fcb_flash_cmd (
    input wire i_core_clk,        // Core clock, 20 MHz
    input wire i_srst,            // Synchronous reset, active high
    input wire i_wr,              // Word store strobe
    input wire i_rd,              // Word load strobe
    input wire [31:0] i_addr,     // Byte address
    input wire [31:0] i_wdata,    // Store data
    output reg [31:0] o_rdata_q,  // Load data
    output reg o_rvalid_q,        // Load data valid
    output reg o_auto_operation_flag_q, // 1 ready, 0 busy
    output reg [3:0] o_protect_q, // Protection bits
    output reg o_ident_mode_q,    // Identification mode active
    output reg o_fail_q           // Automatic operation failed
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_C1 = 3'h1;
    localparam [2:0] ST_C2 = 3'h2;
    localparam [2:0] ST_C3 = 3'h3;
    localparam [2:0] ST_C4 = 3'h4;
    localparam [2:0] ST_C5 = 3'h5;
    localparam [2:0] ST_C6 = 3'h6;
    localparam [2:0] ST_PROG = 3'h7;
    localparam [2:0] OP_NONE = 3'h0;
    localparam [2:0] OP_ER = 3'h1;
    localparam [2:0] OP_PP = 3'h2;
    localparam [2:0] OP_PE = 3'h3;
    localparam [2:0] OP_RUN_PG = 3'h4;
    localparam [2:0] OP_RUN_CE = 3'h5;
    localparam [2:0] OP_RUN_BE = 3'h6;

    // Block number of a byte address
    function [1:0] blk_of;
        input [31:0] a;
        begin
            blk_of = a[`FCB_BLK_HI:`FCB_BLK_LO];
        end
    endfunction

    // Command cycle match: pattern in bits 15:8 and code in data 7:0
    function cyc_is;
        input [31:0] a;
        input [31:0] d;
        input [7:0] pat;
        input [7:0] code;
        begin
            cyc_is = (a[15:8] == pat) && (d[7:0] == code) && (a[1:0] == 2'h0); // [R1] [R2] [R4] [R5]
        end
    endfunction

    // Identification values per selector; values are arbitrary
    function [7:0] ident_value;
        input [1:0] s;
        begin
            case (s)
                2'h0: ident_value = 8'h11;
                2'h1: ident_value = 8'h22;
                2'h3: ident_value = 8'h33;
                default: ident_value = 8'h00;
            endcase
        end
    endfunction

    reg [2:0] st_q;
    reg [2:0] op_q;
    reg [15:0] cnt_q;
    reg [16:0] pg_addr_q;
    reg [1:0] pg_idx_q;
    reg [1:0] er_blk_q;
    reg [3:0] gap_q;
    reg rd_pend_q;
    reg id_rd_q;
    reg [1:0] id_sel_q;
    reg mem_we;
    reg [16:0] mem_addr;
    reg [31:0] mem_wdata;
    wire [31:0] mem_rdata;
    wire busy = (op_q >= OP_RUN_PG) || o_fail_q;

    fcb_mem u_mem (
        .i_core_clk(i_core_clk),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    // Array port: program words go to the page in ascending order
    always @* begin
        mem_we = 1'b0;
        mem_addr = i_addr[18:2];                  // [R13]
        mem_wdata = i_wdata;
        if (st_q == ST_PROG && i_wr && !busy && !o_protect_q[blk_of(i_addr)]) begin // [R17]
            mem_we = 1'b1;
            if (pg_idx_q == 2'h0) begin
                mem_addr = {i_addr[18:4], 2'h0}; // [R10]
            end else begin
                mem_addr = pg_addr_q + {15'h0, pg_idx_q}; // [R9]
            end
        end
    end

    // Sequencer: cycle tracking, automatic operations, protection
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            st_q <= ST_IDLE;
            op_q <= OP_NONE;
            cnt_q <= 16'h0000;
            pg_addr_q <= 17'h00000;
            pg_idx_q <= 2'h0;
            er_blk_q <= 2'h0;
            gap_q <= 4'h0;
            rd_pend_q <= 1'b0;
            id_rd_q <= 1'b0;
            id_sel_q <= 2'h0;
            o_rdata_q <= 32'h00000000;
            o_rvalid_q <= 1'b0;
            o_auto_operation_flag_q <= 1'b1;
            o_protect_q <= `FCB_PROT_RST;
            o_ident_mode_q <= 1'b0;
            o_fail_q <= 1'b0;
        end else begin
            rd_pend_q <= i_rd;
            id_rd_q <= o_ident_mode_q;
            o_rvalid_q <= rd_pend_q;
            // Load answer: array word or identification value
            if (rd_pend_q) begin
                o_rdata_q <= id_rd_q ? {24'h000000, ident_value(id_sel_q)} : mem_rdata; // [R3] [R8]
            end
            // Spacing counter; a too-close write outside ST_IDLE flags failure
            if (gap_q != 4'h0) begin
                gap_q <= gap_q - 4'h1;
            end
            if (i_wr) begin
                gap_q <= `FCB_GAP_LOAD;
                if (gap_q != 4'h0 && st_q != ST_IDLE) begin
                    o_fail_q <= 1'b1;               // [R6] [R15]
                end
            end
            // Automatic operation timer
            if (op_q >= OP_RUN_PG) begin
                if (cnt_q == 16'h0000) begin
                    op_q <= OP_NONE;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
            o_auto_operation_flag_q <= !busy;      // [R15]
            if (i_wr && !busy) begin
                case (st_q)
                    ST_IDLE: begin
                        if (i_wdata[7:0] == `FCB_CMD_RD) begin
                            o_ident_mode_q <= 1'b0; // [R16]
                        end else if (cyc_is(i_addr, i_wdata, `FCB_ADR_55, `FCB_CMD_AA)) begin
                            st_q <= ST_C1;          // [R14]
                        end else if (o_ident_mode_q) begin
                            // Repeated select write while in identification mode
                            id_sel_q <= i_addr[`FCB_SEL_HI:`FCB_SEL_LO]; // [R16]
                        end
                    end
                    ST_C1: begin
                        st_q <= cyc_is(i_addr, i_wdata, `FCB_ADR_AA, `FCB_CMD_55) ? ST_C2 : ST_IDLE;
                    end
                    ST_C2: begin
                        st_q <= ST_IDLE;
                        if (i_addr[15:8] == `FCB_ADR_55) begin
                            if (i_wdata[7:0] == `FCB_CMD_RD) begin
                                o_ident_mode_q <= 1'b0; // [R16]
                            end else if (i_wdata[7:0] == `FCB_CMD_ID) begin
                                st_q <= ST_C3;
                            end else if (i_wdata[7:0] == `FCB_CMD_PG) begin
                                st_q <= ST_PROG;
                                pg_idx_q <= 2'h0;
                            end else if (i_wdata[7:0] == `FCB_CMD_ER) begin
                                st_q <= ST_C3;
                                op_q <= OP_ER;
                            end else if (i_wdata[7:0] == `FCB_CMD_PP) begin
                                st_q <= ST_C3;
                                op_q <= OP_PP;
                            end else if (i_wdata[7:0] == `FCB_CMD_PE) begin
                                st_q <= ST_C3;
                                op_q <= OP_PE;
                            end
                        end
                    end
                    ST_C3: begin
                        if (op_q == OP_NONE) begin
                            // Identification select write; mode sticks
                            id_sel_q <= i_addr[`FCB_SEL_HI:`FCB_SEL_LO];
                            o_ident_mode_q <= 1'b1;  // [R16]
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= cyc_is(i_addr, i_wdata, `FCB_ADR_55, `FCB_CMD_AA) ? ST_C4 : ST_IDLE;
                            if (!cyc_is(i_addr, i_wdata, `FCB_ADR_55, `FCB_CMD_AA)) begin
                                op_q <= OP_NONE;
                            end
                        end
                    end
                    ST_C4: begin
                        st_q <= cyc_is(i_addr, i_wdata, `FCB_ADR_AA, `FCB_CMD_55) ? ST_C5 : ST_IDLE;
                        if (!cyc_is(i_addr, i_wdata, `FCB_ADR_AA, `FCB_CMD_55)) begin
                            op_q <= OP_NONE;
                        end
                    end
                    ST_C5: begin
                        st_q <= ST_IDLE;
                        op_q <= OP_NONE;
                        if (op_q == OP_ER && i_wdata[7:0] == `FCB_CMD_CE) begin
                            if (o_protect_q == 4'h0) begin
                                op_q <= OP_RUN_CE;
                                cnt_q <= `FCB_ERASE_CYC;
                            end
                        end else if (op_q == OP_ER && i_wdata[7:0] == `FCB_CMD_BE) begin
                            er_blk_q <= blk_of(i_addr); // [R11] [R13]
                            if (!o_protect_q[blk_of(i_addr)]) begin // [R17]
                                op_q <= OP_RUN_BE;
                                cnt_q <= `FCB_ERASE_CYC;
                            end
                        end else if (op_q != OP_ER && i_addr[15:8] == `FCB_ADR_55) begin
                            st_q <= ST_C6;
                            op_q <= op_q;
                        end
                    end
                    ST_C6: begin
                        st_q <= ST_IDLE;
                        op_q <= OP_RUN_PG;
                        cnt_q <= `FCB_PROG_CYC;
                        if (op_q == OP_PP) begin
                            o_protect_q[i_addr[`FCB_SEL_HI:`FCB_SEL_LO]] <= 1'b1; // [R12]
                        end else if (i_addr[`FCB_SEL_HI]) begin
                            o_protect_q[3:2] <= 2'h0; // [R18]
                        end else begin
                            o_protect_q[1:0] <= 2'h0; // [R18]
                        end
                    end
                    default: begin
                        // Page programming words, ascending
                        pg_idx_q <= pg_idx_q + 2'h1;    // [R9]
                        if (pg_idx_q == 2'h0) begin
                            pg_addr_q <= {i_addr[18:4], 2'h0}; // [R10]
                        end
                        if (pg_idx_q == `FCB_PAGE_LAST) begin
                            st_q <= ST_IDLE;
                            op_q <= OP_RUN_PG;
                            cnt_q <= `FCB_PROG_CYC;
                        end
                    end
                endcase
            end
        end
    end

endmodule // fcb_flash_cmd

/* File: rtl/fcb_mem.v */
// Word memory for the flash array, registered read data.
// Assumes one read or one write port access per clock.
`timescale 1ns/1ps
module fcb_mem (
    input wire i_core_clk,        // Core clock
    input wire i_we,              // Write enable
    input wire [16:0] i_addr,     // Word address
    input wire [31:0] i_wdata,    // Write data
    output reg [31:0] o_rdata     // Registered read data
);
    reg [31:0] mem [0:131071];
    // Synchronous write, registered read
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule // fcb_mem

/* File: tb/fcb_cpu_model.sv */
// CPU-side model: word stores and loads into the flash command port.
// Assumes the bench calls its tasks; it drives on the falling clock edge.
`timescale 1ns/1ps
module fcb_cpu_model (
    input wire i_core_clk,       // Core clock
    input wire [31:0] i_rdata,   // Load data
    input wire i_rvalid,         // Load data valid
    output logic o_wr,           // Store strobe
    output logic o_rd,           // Load strobe
    output logic [31:0] o_addr,  // Byte address
    output logic [31:0] o_wdata  // Store data
);
    // Idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 32'h0;
        o_wdata = 32'h0;
    end
    // One store pulse, then barrier idle time; released lines show inverted values
    task automatic store(input logic [31:0] a, input logic [31:0] d, input int gap);
        @(negedge i_core_clk);
        o_wr = 1'b1;
        o_addr = {a[31:2], 2'b00};
        o_wdata = d;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
        repeat (gap) @(negedge i_core_clk);
    endtask
    // One load pulse, catch the answer, then barrier idle time
    task automatic load(input logic [31:0] a, output logic [31:0] d);
        int i;
        @(negedge i_core_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = 32'hFFFF_FFFF;
        for (i = 0; i < 4; i++) begin
            @(negedge i_core_clk);
            if (i_rvalid === 1'b1) d = i_rdata;
        end
        repeat (12) @(negedge i_core_clk);
    endtask
endmodule // fcb_cpu_model

/* File: tb/fcb_flash_cmd_properties.sv */
// Timing checks on the flash command sequencer ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module fcb_flash_cmd_properties (
    input wire i_core_clk,              // Core clock
    input wire i_srst,                  // Sync reset
    input wire i_wr,                    // Store strobe
    input wire i_rd,                    // Load strobe
    input wire [31:0] i_addr,           // Byte address
    input wire [31:0] i_wdata,          // Store data
    input wire [31:0] o_rdata_q,        // Load data
    input wire o_rvalid_q,              // Load data valid
    input wire o_auto_operation_flag_q, // Ready flag
    input wire [3:0] o_protect_q,       // Protection bits
    input wire o_ident_mode_q,          // Identification mode
    input wire o_fail_q                 // Sticky failure
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // Load answers and their width
    rvalid_lat_a:
        assert property (i_rd |-> ##2 o_rvalid_q) else $error("load answer missing");
    rvalid_one_a:
        assert property (o_rvalid_q |=> !o_rvalid_q) else $error("load answer too long");
    // Identification mode only left by a read/reset code
    ident_hold_a:
        assert property (o_ident_mode_q && !(i_wr && i_wdata[7:0] == 8'hF0) |=> o_ident_mode_q)
            else $error("ident mode dropped");
    // Protection bits set one at a time, cleared in pairs
    prot_pair_a:
        assert property (!$past(i_srst) |->
            ((($past(o_protect_q[1:0]) & ~o_protect_q[1:0]) == 2'h0 || o_protect_q[1:0] == 2'h0)
            && (($past(o_protect_q[3:2]) & ~o_protect_q[3:2]) == 2'h0
            || o_protect_q[3:2] == 2'h0))) else $error("protection clear not paired");
    prot_one_a:
        assert property (!$past(i_srst) |-> $onehot0(o_protect_q & ~$past(o_protect_q)))
            else $error("several protection bits set");
    // Failure holds busy until reset
    fail_hold_a:
        assert property (o_fail_q |=> o_fail_q ##1 (o_fail_q && !o_auto_operation_flag_q))
            else $error("failure released");
    // Busy only follows a store, and ends or turns to failure in bounded time
    busy_cause_a:
        assert property ($fell(o_auto_operation_flag_q) |-> $past(i_wr) || $past(i_wr, 2)
            || $past(i_wr, 3)) else $error("busy without store");
    busy_bound_a:
        assert property ($fell(o_auto_operation_flag_q) |-> ##[1:400]
            (o_auto_operation_flag_q || o_fail_q)) else $error("busy too long");
endmodule // fcb_flash_cmd_properties
bind fcb_flash_cmd fcb_flash_cmd_properties chk (.i_core_clk, .i_srst, .i_wr, .i_rd,
    .i_addr, .i_wdata, .o_rdata_q, .o_rvalid_q, .o_auto_operation_flag_q, .o_protect_q,
    .o_ident_mode_q, .o_fail_q);

/* File: tb/test_flash_command_bus_cycles.sv */
// Bench for the flash command sequencer: command sequences and results.
// Assumes the CPU model and checker files are compiled before it.
`timescale 1ns/1ps
module test_flash_command_bus_cycles;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_wr, i_rd, o_rvalid_q, o_auto_operation_flag_q, o_ident_mode_q, o_fail_q;
    logic [31:0] i_addr, i_wdata, o_rdata_q, rd;
    logic [3:0] o_protect_q;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    fcb_flash_cmd uut (.i_core_clk, .i_srst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata_q,
        .o_rvalid_q, .o_auto_operation_flag_q, .o_protect_q, .o_ident_mode_q, .o_fail_q);
    fcb_cpu_model cpu (.i_core_clk, .i_rdata(o_rdata_q), .i_rvalid(o_rvalid_q), .o_wr(i_wr),
        .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
    // Clock, 50 ns period
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Flags packed as valid, ready, protect, ident, fail
    function automatic logic [31:0] st();
        return {24'h0, o_rvalid_q, o_auto_operation_flag_q, o_protect_q, o_ident_mode_q,
            o_fail_q};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rst();
        i_srst = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_srst = 1'b0;
    endtask
    task automatic cmd(input logic [15:0] u, input logic [7:0] pat, input logic [7:0] c);
        cpu.store({u, pat, 8'h00}, {24'h0, c}, 14);
    endtask
    // Opening three cycles of a sequence
    task automatic head(input logic [15:0] u, input logic [7:0] c);
        cmd(u, 8'h55, 8'hAA);
        cmd(u, 8'hAA, 8'h55);
        cmd(u, 8'h55, c);
    endtask
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 2000 && o_auto_operation_flag_q !== 1'b1; i++) @(negedge i_core_clk);
        chk(st() & 32'h40, 32'h40);
    endtask
    task automatic t_prog();
        int k;
        head(16'hBFC2, 8'hA0);
        for (k = 0; k < 4; k++) cpu.store(32'hBFC2_0010 + 4 * k, 32'hA5A5_0000 + k, 14);
        chk(st(), 32'h00);
        wait_rdy();
        for (k = 0; k < 4; k++) begin
            cpu.load(32'hBFC2_0010 + 4 * k, rd);
            chk(rd, 32'hA5A5_0000 + k);
        end
    endtask
    task automatic t_ident();
        int s;
        logic [7:0] id [4] = '{8'h11, 8'h22, 8'h00, 8'h33};
        head(16'hBFC0, 8'h90);
        for (s = 0; s < 4; s++) begin
            cpu.store({16'hBFC0, s[1:0], 14'h0}, 32'h0, 14);
            cpu.load(32'hBFC2_0010, rd);
            chk(rd[7:0], id[s]);
            chk(st(), 32'h42);
        end
        cpu.store(32'hBFC0_0000, 32'hF0, 14);
        chk(st(), 32'h40);
        head(16'hBFC0, 8'h90);
        cpu.store(32'hBFC0_0000, 32'h0, 14);
        chk(st(), 32'h42);
        head(16'hBFC0, 8'hF0);
        chk(st(), 32'h40);
        cpu.load(32'hBFC2_0010, rd);
        chk(rd, 32'hA5A5_0000);
    endtask
    // Erase block 0; block 1 keeps its data
    task automatic t_erase();
        head(16'hBFC0, 8'h80);
        cmd(16'hBFC0, 8'h55, 8'hAA);
        cmd(16'hBFC0, 8'hAA, 8'h55);
        cpu.store(32'hBFC0_0000, 32'h30, 14);
        wait_rdy();
        cpu.load(32'hBFC2_0010, rd);
        chk(rd, 32'hA5A5_0000);
    endtask
    task automatic pbit(input logic [7:0] c, input logic [1:0] sel);
        head(16'hBFC0, c);
        head(16'hBFC0, c);
        cpu.store({16'hBFC0, sel, 14'h0}, {24'h0, c}, 14);
        wait_rdy();
    endtask
    task automatic t_prot();
        int b;
        for (b = 0; b < 4; b++) begin
            pbit(8'h9A, b[1:0]);
            chk(o_protect_q, (2 << b) - 1);
        end
        // Chip erase refused while any block is protected
        head(16'hBFC0, 8'h80);
        cmd(16'hBFC0, 8'h55, 8'hAA);
        cmd(16'hBFC0, 8'hAA, 8'h55);
        cmd(16'hBFC0, 8'h55, 8'h10);
        chk(st(), 32'h7C);
        pbit(8'h6A, 2'b10);
        chk(o_protect_q, 4'h3);
        head(16'hBFC2, 8'hA0);
        for (b = 0; b < 4; b++) cpu.store(32'hBFC2_0010 + 4 * b, 32'h0, 14);
        wait_rdy();
        cpu.load(32'hBFC2_0010, rd);
        chk(rd, 32'hA5A5_0000);
        pbit(8'h6A, 2'b01);
        chk(o_protect_q, 4'h0);
    endtask
    // Short store spacing mid-sequence, then reset
    task automatic t_fail();
        cpu.store(32'hBFC0_5500, 32'hAA, 2);
        cpu.store(32'hBFC0_AA00, 32'h55, 14);
        chk(st(), 32'h01);
        rst();
        chk(st(), 32'h40);
    endtask
    initial begin
        rst();
        chk(st(), 32'h40);
        t_prog();
        t_ident();
        t_erase();
        t_prot();
        t_fail();
        end_of_test();
    end
    // Cycle ceiling against a hang
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
endmodule // test_flash_command_bus_cycles
